// file: dv/air_peer.sv
// far-side radio model: stalling octet sink and octet source
`timescale 1ns/1ps
module air_peer (
  input  wire       mclk,          // clock
  input  wire [7:0] air_tx_data,   // octet from formatter
  input  wire       air_tx_valid,  // octet valid
  output reg        air_tx_ready,  // sink takes octet
  output reg  [7:0] air_rx_data,   // octet to formatter
  output reg        air_rx_valid   // octet strobe
);
  integer     seed = 47652;
  logic [7:0] got[$];
  initial begin
    air_tx_ready = 0;
    air_rx_data = 8'hff;
    air_rx_valid = 0;
  end
  // random stalls, so octets must wait for the sink
  always @(negedge mclk) air_tx_ready <= 1'($random(seed));
  always @(posedge mclk) if (air_tx_valid && air_tx_ready) got.push_back(air_tx_data);
  // between strobes the line shows the inverse, so a stale octet never matches
  task send(input logic [7:0] fr[$]);
    foreach (fr[i]) begin
      @(negedge mclk);
      air_rx_valid = 1;
      air_rx_data = fr[i];
      @(negedge mclk);
      air_rx_valid = 0;
      air_rx_data = ~fr[i];
    end
  endtask
endmodule // air_peer

// file: dv/phy_frame_chk_sva.sv
// port checker for the phy frame formatter
`timescale 1ns/1ps
module phy_frame_chk (
  input wire       mclk,            // clock
  input wire       sys_rst,         // reset
  input wire       tx_start,        // tx pulse
  input wire       tx_busy,         // tx level
  input wire [7:0] air_tx_data,     // air octet
  input wire       air_tx_valid,    // air valid
  input wire       air_tx_ready,    // air ready
  input wire       rx_start_evt,    // frame start
  input wire       rx_done,         // frame end
  input wire       rx_frame_avail,  // frame stored
  input wire [7:0] rx_len_octet,    // length octet
  input wire [1:0] rx_len_class,    // length class
  input wire [7:0] host_rd_data,    // readout byte
  input wire       host_rd_valid,   // readout valid
  input wire       host_rd_ready    // readout ready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire [6:0] len = rx_len_octet[6:0];
  chk_busy_start: assert property (tx_start && !tx_busy |=> tx_busy)
    else $error("tx_start did not raise tx_busy");
  chk_pre_first: assert property ($rose(tx_busy) |=>
    air_tx_valid && air_tx_data == 8'h00)
    else $error("first octet is not preamble");
  chk_sfd_soon: assert property ($rose(tx_busy) |->
    ##[1:60] air_tx_valid && air_tx_data == 8'ha7)
    else $error("delimiter missing");
  chk_tx_hold: assert property (air_tx_valid && !air_tx_ready |=>
    air_tx_valid && $stable(air_tx_data))
    else $error("air octet dropped while stalled");
  chk_evt_nonzero: assert property (rx_start_evt |-> len != 7'h00)
    else $error("start event for zero length");
  chk_len_class: assert property (rx_start_evt |-> rx_len_class ==
    (len == 7'h05 ? 2'h1 : len >= 7'h09 ? 2'h2 : 2'h0))
    else $error("wrong length class");
  chk_evt_pulse: assert property (rx_start_evt |=> !rx_start_evt)
    else $error("start event too long");
  chk_avail_set: assert property (rx_done |-> rx_frame_avail)
    else $error("frame flag not set");
  chk_rd_hold: assert property (host_rd_valid && !host_rd_ready |=>
    host_rd_valid && $stable(host_rd_data))
    else $error("readout byte lost");
  cov_rx: cover property (rx_start_evt ##[1:300] rx_done);
  cov_tx: cover property ($fell(tx_busy));
  cov_rd: cover property (host_rd_valid && !host_rd_ready ##1 host_rd_ready);
endmodule // phy_frame_chk
bind phy_frame_formatting phy_frame_chk chk_u (.mclk, .sys_rst, .tx_start, .tx_busy,
  .air_tx_data, .air_tx_valid, .air_tx_ready, .rx_start_evt, .rx_done, .rx_frame_avail,
  .rx_len_octet, .rx_len_class, .host_rd_data, .host_rd_valid, .host_rd_ready);

// file: dv/phy_frame_formatting_bench.sv
// self-checking bench for the phy frame formatter
`timescale 1ns/1ps
module phy_frame_formatting_bench;
  reg         mclk = 0, sys_rst = 1, tx_wr_valid = 0, tx_start = 0;
  reg         host_rd_start = 0, host_rd_ready = 0;
  reg  [7:0]  tx_wr_data = 8'h00;
  wire        tx_wr_ready, tx_busy, air_tx_valid, air_tx_ready, air_rx_valid;
  wire        rx_start_evt, rx_done, rx_frame_avail, host_rd_valid;
  wire [7:0]  air_tx_data, air_rx_data, rx_len_octet, rx_seq_num, host_rd_data;
  wire [1:0]  rx_len_class;
  wire [2:0]  rx_frame_type;
  integer     seed = 47652, num_errors = 0, total_checks = 0;
  integer     evts = 0, dones = 0, e0, d0, i, k, n;
  integer     lens[5] = '{0, 3, 5, 9, 127};
  logic [7:0] fr[$], q[$];
  phy_frame_formatting dut_u (.mclk, .sys_rst, .tx_wr_valid, .tx_wr_data, .tx_wr_ready,
    .tx_start, .tx_busy, .air_tx_data, .air_tx_valid, .air_tx_ready, .air_rx_data,
    .air_rx_valid, .rx_start_evt, .rx_done, .rx_frame_avail, .rx_len_octet, .rx_len_class,
    .rx_frame_type, .rx_seq_num, .host_rd_start, .host_rd_data, .host_rd_valid,
    .host_rd_ready);
  air_peer peer_u (.mclk, .air_tx_data, .air_tx_valid, .air_tx_ready, .air_rx_data,
    .air_rx_valid);
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    evts <= evts + rx_start_evt;
    dones <= dones + rx_done;
  end
  // the host side classifies on the low seven bits only
  function [1:0] cls(input integer l);
    cls = l == 5 ? 2'h1 : l >= 9 ? 2'h2 : 2'h0;
  endfunction
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      num_errors = num_errors + 1;
    end
  endtask
  task wr(input [7:0] b);
    @(negedge mclk);
    tx_wr_valid = 1;
    tx_wr_data = b;
    while (tx_wr_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    tx_wr_valid = 0;
  endtask
  task rd(input integer cnt);
    q = {};
    @(negedge mclk) host_rd_start = 1;
    @(negedge mclk) host_rd_start = 0;
    while (q.size() < cnt) begin
      @(posedge mclk);
      if (host_rd_valid === 1'b1 && host_rd_ready) q.push_back(host_rd_data);
      if (q.size() < cnt) @(negedge mclk) host_rd_ready = 1'($random(seed));
    end
    @(negedge mclk) host_rd_ready = 0;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    num_errors = num_errors + 1;
    test_done;
  end
  initial begin
    repeat (5) @(posedge mclk);
    @(negedge mclk) sys_rst = 0;
    @(negedge mclk);
    for (k = 0; k < 2; k++) begin
      n = k ? 3 : 6;
      fr = {8'h00, 8'h00, 8'h00, 8'h00, 8'ha7, 8'(n + 128 * k)};
      for (i = 0; i < n; i++) fr.push_back(8'($random(seed)));
      peer_u.got = {};
      wr(fr[5]);
      // start before the body is loaded; the header time covers the rest
      @(negedge mclk) tx_start = 1;
      @(negedge mclk) tx_start = 0;
      for (i = 6; i < fr.size(); i++) wr(fr[i]);
      repeat (3000) if (tx_busy === 1'b1) @(posedge mclk);
      chk("tx idle", 8'(tx_busy), 8'h00);
      repeat (20) @(posedge mclk);
      chk("tx count", 8'(peer_u.got.size()), 8'(fr.size()));
      for (i = 0; i < fr.size(); i++) chk("tx octet", peer_u.got[i], fr[i]);
      $display("tx test %0d done", k);
    end
    for (k = 0; k < 5; k++) begin
      n = lens[k];
      fr = {8'h00, 8'h00, 8'h00, 8'h00, 8'ha7, 8'(n + 128 * (k % 2))};
      for (i = 0; i < n; i++) fr.push_back(8'($random(seed)));
      e0 = evts;
      d0 = dones;
      peer_u.send(fr);
      repeat (4) @(posedge mclk);
      chk("rx events", 8'(evts - e0), 8'(n != 0));
      chk("rx done", 8'(dones - d0), 8'(n != 0));
      chk("rx avail", 8'(rx_frame_avail), 8'(n != 0));
      if (n) begin
        chk("rx length", rx_len_octet, fr[5]);
        chk("rx class", 8'(rx_len_class), 8'(cls(n)));
        chk("rx type", 8'(rx_frame_type), 8'(fr[6][2:0]));
        chk("rx seq", rx_seq_num, fr[8]);
        rd(n + 1);
        for (i = 0; i <= n; i++) chk("rd octet", q[i], fr[i + 5]);
        chk("rd avail", 8'(rx_frame_avail), 8'h00);
      end
      $display("rx test length %0d done", n);
    end
    test_done;
  end
endmodule // phy_frame_formatting_bench

// file: hdl/frame_ram.v
// frame buffer storage, one write port and a registered read port
`timescale 1ns/1ps
module frame_ram #(
  parameter AW = 7,
  parameter DW = 8
) (
  input  wire          mclk,   // clock
  input  wire          we,     // write strobe
  input  wire [AW-1:0] waddr,  // write address
  input  wire [DW-1:0] wdata,  // write data
  input  wire [AW-1:0] raddr,  // read address
  output reg  [DW-1:0] rdata   // read data, one cycle after raddr
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // frame_ram

// file: hdl/phy_frame_defs.vh
// constants for the phy frame formatter
`ifndef PHY_FRAME_DEFS_VH
`define PHY_FRAME_DEFS_VH
`define PREAMBLE_OCTETS   3'h4
`define PREAMBLE_VALUE    8'h00
`define SFD_VALUE         8'ha7
`define SHR_SYMBOLS       10
`define SYMBOLS_PER_OCTET 2
`define SHR_OCTETS        (`SHR_SYMBOLS / `SYMBOLS_PER_OCTET)
`define LEN_MASK          8'h7f
`define LEN_ACK           7'h05
`define LEN_MPDU_MIN      7'h09
`define FRAME_BUF_DEPTH   8'h80
`define CLASS_RESERVED    2'h0
`define CLASS_ACK         2'h1
`define CLASS_MPDU        2'h2
`define FCF_TYPE_MSB      2
`define IDX_FCF_LO        8'h01
`define IDX_FCF_HI        8'h02
`define IDX_SEQ           8'h03
`endif

// file: hdl/phy_frame_formatting.v
// phy frame formatter: shr generation, sfd sync, length handling, frame buffer
//
// Functional notes
// - transmit four zero octets then sfd 0xa7
// - shr covers late loading; send bytes when available
// - octet after matched sfd is length
// - low seven length bits give psdu count
// - length top bit kept both directions
// - readout delivers length octet first
// - frame-start event for nonzero length
// - zero length frames dropped silently
// - classify length: reserved, ack, mpdu
// - header: fcf, sequence number, addressing; addressing is not parsed
// - fcf first two octets, type bits 2:0
`timescale 1ns/1ps
`include "phy_frame_defs.vh"
module phy_frame_formatting #(
  parameter AW = 7
) (
  input  wire       mclk,            // clock, 20 mhz
  input  wire       sys_rst,         // synchronous reset, active high
  input  wire       tx_wr_valid,     // host frame buffer write strobe
  input  wire [7:0] tx_wr_data,      // host write byte: length, then psdu
  output reg        tx_wr_ready,     // write can be taken
  input  wire       tx_start,        // start transmission pulse
  output reg        tx_busy,         // transmission in progress
  output reg  [7:0] air_tx_data,     // octet to modulator
  output reg        air_tx_valid,    // octet valid
  input  wire       air_tx_ready,    // modulator takes octet
  input  wire [7:0] air_rx_data,     // octet from demodulator
  input  wire       air_rx_valid,    // octet strobe
  output reg        rx_start_evt,    // frame start event pulse
  output reg        rx_done,         // frame complete pulse
  output reg        rx_frame_avail,  // stored frame not yet read out
  output reg  [7:0] rx_len_octet,    // received length octet, top bit kept
  output reg  [1:0] rx_len_class,    // length class
  output reg  [2:0] rx_frame_type,   // frame type of received frame
  output reg  [7:0] rx_seq_num,      // sequence number of received frame
  input  wire       host_rd_start,   // start frame buffer readout pulse
  output reg  [7:0] host_rd_data,    // readout byte
  output reg        host_rd_valid,   // readout byte valid
  input  wire       host_rd_ready    // host takes readout byte
);
  localparam [4:0] T_IDLE  = 5'h01;
  localparam [4:0] T_SHR   = 5'h02;
  localparam [4:0] T_FETCH = 5'h04;
  localparam [4:0] T_WAIT  = 5'h08;
  localparam [4:0] T_SEND  = 5'h10;
  localparam [3:0] R_HUNT  = 4'h1;
  localparam [3:0] R_SFD   = 4'h2;
  localparam [3:0] R_LEN   = 4'h4;
  localparam [3:0] R_BODY  = 4'h8;

  reg  [4:0]    tx_state_reg;
  reg  [2:0]    shr_cnt_reg;
  reg  [7:0]    tx_idx_reg;
  reg  [6:0]    tx_len_reg;
  reg  [7:0]    wr_cnt_reg;
  reg  [3:0]    rx_state_reg;
  reg  [3:0]    rx_state_next;
  reg  [2:0]    zero_cnt_reg;
  reg  [7:0]    rx_idx_reg;
  reg  [6:0]    rx_len_reg;
  reg           rd_active_reg;
  reg  [7:0]    rd_addr_reg;
  reg           inflight_reg;
  reg  [7:0]    buf1_reg;
  reg  [1:0]    cnt_reg;
  reg  [1:0]    cnt_next;
  wire [7:0]    ram_rdata;
  wire          host_wr;
  wire          rx_we;
  wire          issue;
  wire          pop;
  wire          tx_last;
  wire [7:0]    wr_cnt_next;

  assign host_wr = tx_wr_valid && tx_wr_ready;
  // receiver owns the write port only while tx_wr_ready is low
  assign rx_we   = air_rx_valid && ((rx_state_reg == R_BODY) ||
                   ((rx_state_reg == R_LEN) && (air_rx_data[6:0] != 7'h00)));
  assign issue   = rd_active_reg && !tx_busy &&
                   (({1'b0, cnt_reg} + {2'b00, inflight_reg}) < 3'h2);
  assign pop     = host_rd_valid && host_rd_ready;
  assign tx_last = (tx_state_reg == T_SEND) && (!air_tx_valid || air_tx_ready) &&
                   (tx_idx_reg == {1'b0, ((tx_idx_reg == 8'h00) ?
                                          (ram_rdata[6:0]) : tx_len_reg)});
  assign wr_cnt_next = tx_last ? 8'h00 : (wr_cnt_reg + {7'h00, host_wr});

  frame_ram #(
    .AW (AW),
    .DW (8)
  ) u_ram (
    .mclk  (mclk),
    .we    (rx_we || host_wr),
    .waddr (rx_we ? rx_idx_reg[AW-1:0] : wr_cnt_reg[AW-1:0]),
    .wdata (rx_we ? air_rx_data : tx_wr_data),
    .raddr (tx_busy ? tx_idx_reg[AW-1:0] : rd_addr_reg[AW-1:0]),
    .rdata (ram_rdata)
  );

  // transmit: header is generated here, buffer holds length and psdu only
  always @(posedge mclk) begin
    if (sys_rst) begin
      tx_state_reg <= T_IDLE;
      shr_cnt_reg  <= 3'h0;
      tx_idx_reg   <= 8'h00;
      tx_len_reg   <= 7'h00;
      tx_busy      <= 1'b0;
      air_tx_data  <= 8'h00;
      air_tx_valid <= 1'b0;
    end else begin
      if (air_tx_ready) begin
        air_tx_valid <= 1'b0;
      end
      case (tx_state_reg)
        T_IDLE: begin
          if (tx_start) begin
            tx_busy      <= 1'b1;
            shr_cnt_reg  <= 3'h0;
            tx_idx_reg   <= 8'h00;
            tx_state_reg <= T_SHR;
          end
        end
        T_SHR: begin
          if (!air_tx_valid || air_tx_ready) begin
            air_tx_valid <= 1'b1;
            air_tx_data  <= (shr_cnt_reg == `PREAMBLE_OCTETS) ?
                            `SFD_VALUE : `PREAMBLE_VALUE;
            shr_cnt_reg  <= shr_cnt_reg + 3'h1;
            if (shr_cnt_reg == `PREAMBLE_OCTETS) begin
              tx_state_reg <= T_FETCH;
            end
          end
        end
        T_FETCH: begin
          // wait for the host to have written this byte
          if (tx_idx_reg < wr_cnt_reg) begin
            tx_state_reg <= T_WAIT;
          end
        end
        T_WAIT: begin
          tx_state_reg <= T_SEND;
        end
        T_SEND: begin
          if (!air_tx_valid || air_tx_ready) begin
            air_tx_valid <= 1'b1;
            air_tx_data  <= ram_rdata;
            if (tx_idx_reg == 8'h00) begin
              tx_len_reg <= ram_rdata[6:0];
            end
            if (tx_last) begin
              tx_busy      <= 1'b0;
              tx_state_reg <= T_IDLE;
            end else begin
              tx_idx_reg   <= tx_idx_reg + 8'h01;
              tx_state_reg <= T_FETCH;
            end
          end
        end
        default: begin
          tx_state_reg <= T_IDLE;
          tx_busy      <= 1'b0;
        end
      endcase
    end
  end

  // host write pointer; rewinds when the last octet is loaded into air_tx_data, before the sink takes it
  always @(posedge mclk) begin
    if (sys_rst) begin
      wr_cnt_reg  <= 8'h00;
      tx_wr_ready <= 1'b0;
    end else begin
      wr_cnt_reg  <= wr_cnt_next;
      tx_wr_ready <= (rx_state_next != R_LEN) && (rx_state_next != R_BODY) &&
                     (wr_cnt_next < `FRAME_BUF_DEPTH);
    end
  end

  always @* begin
    rx_state_next = rx_state_reg;
    if (air_rx_valid) begin
      case (rx_state_reg)
        R_HUNT: begin
          if ((air_rx_data == `PREAMBLE_VALUE) &&
              (zero_cnt_reg == `PREAMBLE_OCTETS - 3'h1)) begin
            rx_state_next = R_SFD;
          end
        end
        R_SFD: begin
          if (air_rx_data == `SFD_VALUE) begin
            rx_state_next = R_LEN;
          end else if (air_rx_data != `PREAMBLE_VALUE) begin
            rx_state_next = R_HUNT;
          end
        end
        R_LEN: begin
          // zero length: back to hunting, no trace left
          rx_state_next = (air_rx_data[6:0] == 7'h00) ? R_HUNT : R_BODY;
        end
        R_BODY: begin
          if (rx_idx_reg == {1'b0, rx_len_reg}) begin
            rx_state_next = R_HUNT;
          end
        end
        default: begin
          rx_state_next = R_HUNT;
        end
      endcase
    end
  end

  // receive: preamble sync, sfd match, length, psdu
  always @(posedge mclk) begin
    if (sys_rst) begin
      rx_state_reg   <= R_HUNT;
      zero_cnt_reg   <= 3'h0;
      rx_idx_reg     <= 8'h00;
      rx_len_reg     <= 7'h00;
      rx_start_evt   <= 1'b0;
      rx_done        <= 1'b0;
      rx_frame_avail <= 1'b0;
      rx_len_octet   <= 8'h00;
      rx_len_class   <= `CLASS_RESERVED;
      rx_frame_type  <= 3'h0;
      rx_seq_num     <= 8'h00;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_start_evt <= 1'b0;
      rx_done      <= 1'b0;
      if (host_rd_start && !tx_busy) begin
        rx_frame_avail <= 1'b0;
      end
      if (air_rx_valid) begin
        if (rx_state_reg == R_HUNT) begin
          zero_cnt_reg <= (air_rx_data != `PREAMBLE_VALUE) ? 3'h0 :
                          (zero_cnt_reg + 3'h1);
        end else begin
          zero_cnt_reg <= 3'h0;
        end
        if ((rx_state_reg == R_LEN) && (air_rx_data[6:0] != 7'h00)) begin
          rx_start_evt <= 1'b1;
          rx_len_reg   <= air_rx_data[6:0];
          rx_len_octet <= air_rx_data;
          rx_idx_reg   <= 8'h01;
          if (air_rx_data[6:0] == `LEN_ACK) begin
            rx_len_class <= `CLASS_ACK;
          end else if (air_rx_data[6:0] >= `LEN_MPDU_MIN) begin
            rx_len_class <= `CLASS_MPDU;
          end else begin
            rx_len_class <= `CLASS_RESERVED;
          end
        end
        if (rx_state_reg == R_BODY) begin
          rx_idx_reg <= rx_idx_reg + 8'h01;
          if (rx_idx_reg == `IDX_FCF_LO) begin
            rx_frame_type <= air_rx_data[`FCF_TYPE_MSB:0];
          end
          if (rx_idx_reg == `IDX_SEQ) begin
            rx_seq_num <= air_rx_data;
          end
          if (rx_idx_reg == {1'b0, rx_len_reg}) begin
            rx_done        <= 1'b1;
            rx_idx_reg     <= 8'h00;  // next length octet lands at address 0
            rx_frame_avail <= 1'b1;  // a new frame wins over a readout start
          end
        end
      end
    end
  end

  // readout issues: address 0 is the length octet, then psdu in air order
  always @(posedge mclk) begin
    if (sys_rst) begin
      rd_active_reg <= 1'b0;
      rd_addr_reg   <= 8'h00;
      inflight_reg  <= 1'b0;
    end else begin
      inflight_reg <= issue;
      if (host_rd_start && !tx_busy) begin
        rd_active_reg <= 1'b1;
        rd_addr_reg   <= 8'h00;
      end else if (issue) begin
        rd_addr_reg <= rd_addr_reg + 8'h01;
        if (rd_addr_reg == {1'b0, rx_len_reg}) begin
          rd_active_reg <= 1'b0;
        end
      end
    end
  end

  // two-entry buffer ahead of the host so a stall never drops a byte
  always @* begin
    cnt_next = cnt_reg;
    case ({inflight_reg, pop})
      2'b10: cnt_next = cnt_reg + 2'h1;
      2'b01: cnt_next = cnt_reg - 2'h1;
      default: cnt_next = cnt_reg;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      buf1_reg      <= 8'h00;
      cnt_reg       <= 2'h0;
      host_rd_data  <= 8'h00;
      host_rd_valid <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      // host_rd_data is the head entry; buf1 holds the one behind it
      if (inflight_reg && (cnt_next == 2'h2)) begin
        buf1_reg <= ram_rdata;
      end
      host_rd_valid <= (cnt_next != 2'h0);
      if ((cnt_next != 2'h0) && ((cnt_reg == 2'h0) || pop)) begin
        host_rd_data <= (pop && (cnt_reg == 2'h2)) ? buf1_reg :
                        ((cnt_reg == 2'h0) || (cnt_reg == 2'h1)) ? ram_rdata : buf1_reg;
      end
    end
  end
endmodule // phy_frame_formatting
